// File: bench/acf_peer.sv
// Remote serial sender feeding received characters
`timescale 1ns/1ps
module acf_peer (
  input wire logic clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic [7:0] q[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // Hold a char until taken; idle data keeps changing
  always @(posedge clk) begin
    if (!rx_valid || rx_ready) begin
      if (q.size() > 0) begin
        rx_valid <= 1'b1;
        rx_data <= q.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
  end
endmodule

// File: bench/acf_sva.sv
// Port checker for the flow character option block
`timescale 1ns/1ps
module acf_sva #(
  parameter int DATA_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic [DATA_W-1:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_load_enable,
  input wire logic tx_flow_stopped,
  input wire logic rx_threshold_hit,
  input wire logic flowctl_transparency,
  input wire logic special_char_detect_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  chk_mode_write: assert property (
    $changed({flowctl_transparency, special_char_detect_en})
    |-> $past(psel && penable && pwrite && paddr == 8'h14))
    else $error("mode bits moved without a write");
  chk_stop_inverse: assert property (tx_flow_stopped != tx_load_enable)
    else $error("load enable not inverse of stop");
  chk_stop_cause: assert property (
    $rose(tx_flow_stopped) |-> $past(rx_valid && rx_ready))
    else $error("stop without a received char");
  chk_resume_cause: assert property (
    $fell(tx_flow_stopped) |-> $past(rx_valid && rx_ready)
    || $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
    else $error("resume without char or write");
  chk_thr_cause: assert property (
    $rose(rx_threshold_hit) |-> $past(rx_valid && rx_ready)
    || $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
    else $error("threshold hit without cause");
  chk_full_hold: assert property (!rx_ready && !(psel && penable) |=> !rx_ready)
    else $error("full fifo freed without a read");
  cover property ($rose(tx_flow_stopped));
  cover property ($fell(tx_flow_stopped));
  cover property (!rx_ready);
  cover property (pslverr);
endmodule
bind acf_top acf_sva #(.DATA_W(DATA_W)) chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_ready,
  .tx_load_enable, .tx_flow_stopped, .rx_threshold_hit, .flowctl_transparency,
  .special_char_detect_en);

// File: bench/acf_top_tb.sv
// Self-checking bench for the flow character option block
`timescale 1ns/1ps
module acf_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid, rx_ready;
  logic [7:0] paddr, rx_data;
  logic [31:0] pwdata, prdata;
  logic tx_load_enable, tx_flow_stopped, rx_threshold_hit;
  logic flowctl_transparency, special_char_detect_en;
  int errors, tests_run;
  logic [32:0] exp_q[$];
  logic [7:0] fill[$];
  logic [7:0] sc[4] = '{8'h11, 8'h13, 8'h21, 8'h23};
  logic [32:0] tbl[11] = '{33'h1_0101_1355, 33'h0_0101_1155, 33'h0_4101_1355,
    33'h1_4101_1323, 33'h1_c101_1155, 33'h0_c101_1121, 33'h1_0103_5513,
    33'h0_0103_1377, 33'h0_0100_1313, 33'h1_0101_5513, 33'h0_0105_5555};
  logic [3:0] thr;
  acf_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_valid, .rx_data, .rx_ready, .tx_load_enable, .tx_flow_stopped,
    .rx_threshold_hit, .flowctl_transparency, .special_char_detect_en);
  acf_peer peer_u (.clk(pclk), .rx_ready, .rx_valid, .rx_data);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task tally_and_finish;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input string nm, input logic [32:0] s, input logic [32:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      errors++;
      tally_and_finish;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task settle(input bit full);
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (peer_u.q.size() == 0 && (full || rx_valid !== 1'b1)) break;
    end
    if (n == 50) begin
      errors++;
      tally_and_finish;
    end
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  task flow(input logic [32:0] t);
    apb(1'b1, 8'h14, {24'h0, t[31:24]}, 33'h0);
    apb(1'b1, 8'h18, {24'h0, t[23:16]}, 33'h0);
    peer_u.q.push_back(t[15:8]);
    peer_u.q.push_back(t[7:0]);
    settle(1'b0);
    check("stopped", tx_flow_stopped, t[32]);
    check("load", tx_load_enable, !t[32]);
    apb(1'b0, 8'h1c, 32'h0, {25'h0, 7'h11, t[32]});
    apb(1'b0, 8'h30, 32'h0, {25'h1, t[15:8]});
    apb(1'b0, 8'h30, 32'h0, {25'h1, t[7:0]});
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) check("apb", {pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    tests_run = 0;
    void'($urandom(41339));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h14, 32'h0, 33'h0);
    apb(1'b1, 8'h14, 32'hb3, 33'h0);
    @(negedge pclk);
    check("mode", {flowctl_transparency, special_char_detect_en}, 2'b11);
    apb(1'b0, 8'h14, 32'h0, 33'hb3);
    apb(1'b0, 8'hfc, 32'h0, 33'h1_0000_0000);
    apb(1'b1, 8'hfc, 32'h5a, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++) apb(1'b1, 8'h20 + 8'(4 * i), {24'h0, sc[i]}, 33'h0);
    foreach (tbl[i]) flow(tbl[i]);
    // Threshold kept in 1 to 8
    thr = 4'(1 + $urandom % 8);
    apb(1'b1, 8'h18, 32'h0, 33'h0);
    apb(1'b1, 8'h14, {28'h0, thr}, 33'h0);
    for (int i = 0; i < 9; i++) begin
      fill.push_back(8'h40 | 8'($urandom % 16));
      peer_u.q.push_back(fill[i]);
      settle(i == 8);
      if (i < 8) check("thr", rx_threshold_hit, (i + 1 >= thr));
    end
    check("full", rx_ready, 1'b0);
    foreach (fill[i]) apb(1'b0, 8'h30, 32'h0, {25'h1, fill[i]});
    tally_and_finish;
  end
endmodule

// File: common/acf_pkg.sv
// Constants, register map and types for the flow character option block
// How it works
// - Host writes to the option register take effect at once, no command needed.
// - Xoff pair select clear: Xoff is a single match of special char 2.
// - Xoff pair select set: Xoff is special char 2 then special char 4.
// - Threshold field bits 3:0 gives 1 to 8 characters; software never writes 0.
// - With in-band flow control on, a recognised Xoff stops new transmit loads.
// - After Xoff, resume on any non-Xoff character in implied mode, else only on Xon, a host flow clear or a write clearing in-band flow control.
package acf_pkg;

  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int ADDR_W = 8;
  localparam int BUS_W = 32;
  localparam int LVL_W = 4;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_OPTION3 = 6'h05;
  localparam logic [5:0] IDX_CTRL = 6'h06;
  localparam logic [5:0] IDX_STATUS = 6'h07;
  localparam logic [5:0] IDX_SPECIAL1 = 6'h08;
  localparam logic [5:0] IDX_SPECIAL2 = 6'h09;
  localparam logic [5:0] IDX_SPECIAL3 = 6'h0a;
  localparam logic [5:0] IDX_SPECIAL4 = 6'h0b;
  localparam logic [5:0] IDX_RXDATA = 6'h0c;

  // Option register three fields
  localparam int XON_PAIR_BIT = 7;
  localparam int XOFF_PAIR_BIT = 6;
  localparam int FCT_BIT = 5;
  localparam int SPECIAL_CHAR_DETECT_EN_BIT = 4;
  localparam int THR_LSB = 0;
  localparam int THR_W = 4;
  localparam logic [7:0] OPTION3_RESET = 8'h00;

  // Control register fields
  localparam int TX_INBAND_FLOWCTL_EN_BIT = 0;
  localparam int IXM_BIT = 1;
  localparam int FLOW_CLR_BIT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [7:0] SPECIAL_RESET = 8'h00;

  // Status register fields
  localparam int STAT_STOPPED_BIT = 0;
  localparam int STAT_THR_BIT = 1;
  localparam int STAT_EMPTY_BIT = 2;
  localparam int STAT_LEVEL_LSB = 4;

  // Receive data register: valid flag above the character
  localparam int RXDATA_VALID_BIT = 8;

  typedef enum logic [0:0] {
    ACF_FLOW_RUN = 1'b0,
    ACF_FLOW_STOPPED = 1'b1
  } acf_flow_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [5:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

endpackage

// File: hw/acf_fifo.sv
// Receive character FIFO with valid and ready on both sides
`timescale 1ns/1ps
module acf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CNT_W-1:0] count
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] cnt;
  } acf_fifo_state_t;

  acf_fifo_state_t state_reg;
  acf_fifo_state_t state_next;
  logic push;
  logic pop;

  assign in_ready = (state_reg.cnt != CNT_W'(DEPTH));
  assign out_valid = (state_reg.cnt != '0);
  assign out_data = state_reg.mem[state_reg.rd_ptr];
  assign count = state_reg.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr_ptr] = in_data;
      state_next.wr_ptr = (state_reg.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : state_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_next.rd_ptr = (state_reg.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : state_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      state_next.cnt = state_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      state_next.cnt = state_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// File: hw/acf_top.sv
// Channel flow character options, Xon/Xoff recognition and receive FIFO behind APB
`timescale 1ns/1ps
module acf_top #(
  parameter int DATA_W = acf_pkg::DATA_W,
  parameter int FIFO_DEPTH = acf_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acf_pkg::ADDR_W-1:0] paddr,
  input wire logic [acf_pkg::BUS_W-1:0] pwdata,
  output logic [acf_pkg::BUS_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [DATA_W-1:0] rx_data,
  output logic rx_ready,
  output logic tx_load_enable,
  output logic tx_flow_stopped,
  output logic rx_threshold_hit,
  output logic flowctl_transparency,
  output logic special_char_detect_en
);

  localparam int LVL_W = acf_pkg::LVL_W;

  typedef struct packed {
    logic [7:0] option3;
    logic [1:0] ctrl;
    logic [3:0][DATA_W-1:0] special;
    acf_pkg::acf_flow_t flow;
    logic xon_pend;
    logic xoff_pend;
    logic [acf_pkg::BUS_W-1:0] rdata;
    logic ready;
    logic slverr;
    logic rx_rdy;
    logic thr_hit;
  } acf_state_t;

  acf_state_t state_reg;
  acf_state_t state_next;

  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic [LVL_W-1:0] fifo_count;
  logic fifo_in_ready;
  logic push;
  logic pop;
  logic setup;
  logic access;

  function automatic logic addr_is(input logic [acf_pkg::ADDR_W-1:0] a,
                                   input logic [5:0] idx);
    addr_is = (a == acf_pkg::byte_addr(idx));
  endfunction

  function automatic logic mapped(input logic [acf_pkg::ADDR_W-1:0] a);
    mapped = addr_is(a, acf_pkg::IDX_OPTION3) || addr_is(a, acf_pkg::IDX_CTRL) ||
             addr_is(a, acf_pkg::IDX_STATUS) || addr_is(a, acf_pkg::IDX_SPECIAL1) ||
             addr_is(a, acf_pkg::IDX_SPECIAL2) || addr_is(a, acf_pkg::IDX_SPECIAL3) ||
             addr_is(a, acf_pkg::IDX_SPECIAL4) || addr_is(a, acf_pkg::IDX_RXDATA);
  endfunction

  assign setup = psel && !penable;
  assign access = psel && penable && state_reg.ready;
  assign push = rx_valid && state_reg.rx_rdy && fifo_in_ready;
  assign pop = access && !pwrite && addr_is(paddr, acf_pkg::IDX_RXDATA) &&
               state_reg.rdata[acf_pkg::RXDATA_VALID_BIT];

  acf_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .CNT_W(LVL_W)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(rx_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  logic [DATA_W-1:0] sc1;
  logic [DATA_W-1:0] sc2;
  logic [DATA_W-1:0] sc3;
  logic [DATA_W-1:0] sc4;
  logic xon_pair;
  logic xoff_pair;
  logic xon_det;
  logic xoff_det;
  logic flow_clr;
  logic [LVL_W:0] level_next;
  logic [acf_pkg::THR_W-1:0] threshold;
  logic [acf_pkg::BUS_W-1:0] rd_word;
  logic [7:0] status_byte;

  assign sc1 = state_reg.special[0];
  assign sc2 = state_reg.special[1];
  assign sc3 = state_reg.special[2];
  assign sc4 = state_reg.special[3];
  assign xon_pair = state_reg.option3[acf_pkg::XON_PAIR_BIT];
  assign xoff_pair = state_reg.option3[acf_pkg::XOFF_PAIR_BIT];
  assign threshold = state_reg.option3[acf_pkg::THR_LSB +: acf_pkg::THR_W];

  always_comb begin
    xon_det = 1'b0;
    xoff_det = 1'b0;
    if (push) begin
      if (xon_pair) begin
        xon_det = state_reg.xon_pend && (rx_data == sc3);
      end else begin
        xon_det = (rx_data == sc1);
      end
      if (xoff_pair) begin
        xoff_det = state_reg.xoff_pend && (rx_data == sc4);
      end else begin
        xoff_det = (rx_data == sc2);
      end
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[acf_pkg::STAT_STOPPED_BIT] = (state_reg.flow == acf_pkg::ACF_FLOW_STOPPED);
    status_byte[acf_pkg::STAT_THR_BIT] = state_reg.thr_hit;
    status_byte[acf_pkg::STAT_EMPTY_BIT] = !fifo_out_valid;
    status_byte[acf_pkg::STAT_LEVEL_LSB +: LVL_W] = fifo_count;
  end

  always_comb begin
    rd_word = '0;
    if (addr_is(paddr, acf_pkg::IDX_OPTION3)) begin
      rd_word[7:0] = state_reg.option3;
    end else if (addr_is(paddr, acf_pkg::IDX_CTRL)) begin
      rd_word[1:0] = state_reg.ctrl;
    end else if (addr_is(paddr, acf_pkg::IDX_STATUS)) begin
      rd_word[7:0] = status_byte;
    end else if (addr_is(paddr, acf_pkg::IDX_SPECIAL1)) begin
      rd_word[DATA_W-1:0] = sc1;
    end else if (addr_is(paddr, acf_pkg::IDX_SPECIAL2)) begin
      rd_word[DATA_W-1:0] = sc2;
    end else if (addr_is(paddr, acf_pkg::IDX_SPECIAL3)) begin
      rd_word[DATA_W-1:0] = sc3;
    end else if (addr_is(paddr, acf_pkg::IDX_SPECIAL4)) begin
      rd_word[DATA_W-1:0] = sc4;
    end else if (addr_is(paddr, acf_pkg::IDX_RXDATA)) begin
      rd_word[DATA_W-1:0] = fifo_out_data;
      rd_word[acf_pkg::RXDATA_VALID_BIT] = fifo_out_valid;
    end
  end

  always_comb begin
    state_next = state_reg;
    flow_clr = 1'b0;
    level_next = {1'b0, fifo_count} + {{LVL_W{1'b0}}, push} - {{LVL_W{1'b0}}, pop};

    // Bus answer one cycle after setup
    state_next.ready = 1'b0;
    state_next.slverr = 1'b0;
    if (setup) begin
      state_next.ready = 1'b1;
      state_next.slverr = !mapped(paddr);
      state_next.rdata = (!pwrite && mapped(paddr)) ? rd_word : '0;
    end

    if (access && pwrite) begin
      if (addr_is(paddr, acf_pkg::IDX_OPTION3)) begin
        state_next.option3 = pwdata[7:0];
      end
      if (addr_is(paddr, acf_pkg::IDX_CTRL)) begin
        state_next.ctrl = pwdata[1:0];
        flow_clr = pwdata[acf_pkg::FLOW_CLR_BIT];
      end
      if (addr_is(paddr, acf_pkg::IDX_SPECIAL1)) begin
        state_next.special[0] = pwdata[DATA_W-1:0];
      end
      if (addr_is(paddr, acf_pkg::IDX_SPECIAL2)) begin
        state_next.special[1] = pwdata[DATA_W-1:0];
      end
      if (addr_is(paddr, acf_pkg::IDX_SPECIAL3)) begin
        state_next.special[2] = pwdata[DATA_W-1:0];
      end
      if (addr_is(paddr, acf_pkg::IDX_SPECIAL4)) begin
        state_next.special[3] = pwdata[DATA_W-1:0];
      end
    end

    // First character of a pair is remembered for the next character only
    if (push) begin
      state_next.xon_pend = xon_pair && (rx_data == sc1);
      state_next.xoff_pend = xoff_pair && (rx_data == sc2);
    end

    // Host clear first, so a same-cycle Xoff still wins
    if (flow_clr) begin
      state_next.flow = acf_pkg::ACF_FLOW_RUN;
    end
    if (!state_reg.ctrl[acf_pkg::TX_INBAND_FLOWCTL_EN_BIT]) begin
      state_next.flow = acf_pkg::ACF_FLOW_RUN;
    end else begin
      unique case (state_reg.flow)
        acf_pkg::ACF_FLOW_RUN: begin
          if (xoff_det) begin
            state_next.flow = acf_pkg::ACF_FLOW_STOPPED;
          end
        end
        acf_pkg::ACF_FLOW_STOPPED: begin
          if (xoff_det) begin
            state_next.flow = acf_pkg::ACF_FLOW_STOPPED;
          end else if (xon_det || (push && state_reg.ctrl[acf_pkg::IXM_BIT])) begin
            state_next.flow = acf_pkg::ACF_FLOW_RUN;
          end
        end
      endcase
    end

    // FIFO space and threshold track the level after this cycle
    state_next.rx_rdy = (level_next < (LVL_W + 1)'(FIFO_DEPTH));
    state_next.thr_hit = (level_next >= {1'b0, threshold}) && (threshold != '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.option3 <= acf_pkg::OPTION3_RESET;
      state_reg.ctrl <= acf_pkg::CTRL_RESET;
      state_reg.special <= {4{acf_pkg::SPECIAL_RESET}};
      state_reg.flow <= acf_pkg::ACF_FLOW_RUN;
      state_reg.xon_pend <= 1'b0;
      state_reg.xoff_pend <= 1'b0;
      state_reg.rdata <= '0;
      state_reg.ready <= 1'b0;
      state_reg.slverr <= 1'b0;
      state_reg.rx_rdy <= 1'b1;
      state_reg.thr_hit <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.slverr;
  assign rx_ready = state_reg.rx_rdy;
  assign tx_load_enable = (state_reg.flow == acf_pkg::ACF_FLOW_RUN);
  assign tx_flow_stopped = (state_reg.flow == acf_pkg::ACF_FLOW_STOPPED);
  assign rx_threshold_hit = state_reg.thr_hit;
  assign flowctl_transparency = state_reg.option3[acf_pkg::FCT_BIT];
  assign special_char_detect_en = state_reg.option3[acf_pkg::SPECIAL_CHAR_DETECT_EN_BIT];

endmodule
